// ===== sar_pkg.sv
package sar_pkg;
  localparam int RESULT_BITS = 18;
  localparam int FRAME_BITS = 19;
  localparam int CNT_W = 5;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MIN_NS = 300;
  localparam int CONV_MAX_NS = 500;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_DONE_CNT = 8'(CONV_MIN_CYC - 1);
  localparam logic [7:0] HOST_WAIT_CNT = 8'(CONV_MAX_CYC);
  localparam logic [7:0] SELECT_HOLD_CNT = 8'h07;
  localparam logic [4:0] SCK_HALF_CNT = 5'h0f;
  localparam logic [CNT_W-1:0] LAST_PLAIN = 5'h12;
  localparam logic [CNT_W-1:0] LAST_BUSY = 5'h13;
  localparam logic [RESULT_BITS-1:0] CODE_RESET = 18'h00000;
  // pin levels at rest: select high, clock, convert and count low
  localparam logic [7:0] PIN_IDLE = 8'h02;

  typedef enum logic [3:0] {
    DEV_IDLE = 4'h1,
    DEV_CONV = 4'h2,
    DEV_DONE = 4'h4,
    DEV_READ = 4'h8
  } sar_dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LAUNCH = 5'h02,
    H_WAIT = 5'h04,
    H_SHIFT = 5'h08,
    H_END = 5'h10
  } sar_host_state_t;

  function automatic logic [CNT_W-1:0] sar_gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : sar_gray2bin
endpackage : sar_pkg

// ===== sar_link_if.sv
`timescale 1ns/1ps
interface sar_link_if;
  logic convertPin;
  logic chainSelectIn;
  logic serialClk;
  logic serialOut;
  logic serialOutEnN;
  logic serialLine;

  // pulled-up shared data line
  assign serialLine = serialOutEnN ? 1'b1 : serialOut;

  modport device (
    input convertPin,
    input chainSelectIn,
    input serialClk,
    output serialOut,
    output serialOutEnN
  );

  modport host (
    output convertPin,
    output chainSelectIn,
    output serialClk,
    input serialLine
  );
endinterface : sar_link_if

// ===== sar_device.sv
`timescale 1ns/1ps
module sar_device
  import sar_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic rst,
  // link
  sar_link_if.device link,
  // converter side
  input wire logic [RESULT_BITS-1:0] sampleCode,
  output logic convActive,
  output logic [RESULT_BITS-1:0] resultCode
);
  localparam int SW = CNT_W + 3;

  // serial clock domain: falling edge counter
  logic [CNT_W-1:0] fallBin = '0;
  logic [CNT_W-1:0] fallGray = '0;
  logic [CNT_W-1:0] next_fallBin;

  assign next_fallBin = fallBin + 5'h01;

  always_ff @(negedge link.serialClk) begin
    fallBin <= next_fallBin;
  end

  always_ff @(negedge link.serialClk) begin
    fallGray <= next_fallBin ^ (next_fallBin >> 1);
  end

  // pin and counter synchronisers
  logic [SW-1:0] pinIn;
  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  logic [SW-1:0] syncC;
  logic [SW-1:0] pinF;

  assign pinIn = {fallGray, link.serialClk, link.chainSelectIn, link.convertPin};

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA <= PIN_IDLE;
      syncB <= PIN_IDLE;
      syncC <= PIN_IDLE;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  for (genvar i = 0; i < SW; i++) begin : g_filt
    always_ff @(posedge mclk) begin
      if (rst) begin
        pinF[i] <= PIN_IDLE[i];
      end else if (syncB[i] == syncC[i]) begin
        pinF[i] <= syncC[i];
      end
    end
  end

  logic cnvF;
  logic sdiF;
  logic sckF;
  logic [CNT_W-1:0] fallCnt;

  assign cnvF = pinF[0];
  assign sdiF = pinF[1];
  assign sckF = pinF[2];
  assign fallCnt = sar_gray2bin(pinF[SW-1:3]);

  logic cnvPrev;
  logic sdiPrev;
  logic cnvRise;
  logic sdiRise;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnvPrev <= 1'b0;
      sdiPrev <= 1'b1;
    end else begin
      cnvPrev <= cnvF;
      sdiPrev <= sdiF;
    end
  end

  assign cnvRise = cnvF & ~cnvPrev;
  assign sdiRise = sdiF & ~sdiPrev;

  // conversion control
  sar_dev_state_t state;
  logic [7:0] convTimer;
  logic selectMode;
  logic chainBusy;
  logic busyNow;
  logic convEnd;
  logic startConv;
  logic enterRead;
  logic [FRAME_BITS-1:0] frame;
  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] lastIdx;
  logic [CNT_W-1:0] idx;
  logic [FRAME_BITS-1:0] shifted;

  assign startConv = cnvRise && (state != DEV_CONV);
  assign convEnd = (state == DEV_CONV) && (convTimer == CONV_DONE_CNT);
  assign busyNow = selectMode ? (!cnvF || !sdiF) : chainBusy;
  assign enterRead = (convEnd && (busyNow || !selectMode))
    || (!startConv && (state == DEV_DONE) && (!cnvF || !sdiF));
  assign idx = fallCnt - base;
  assign shifted = frame << idx;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= DEV_IDLE;
    end else if (startConv) begin
      state <= DEV_CONV;
    end else begin
      unique case (state)
        DEV_IDLE: begin
          state <= DEV_IDLE;
        end
        DEV_CONV: begin
          if (convEnd) begin
            state <= enterRead ? DEV_READ : DEV_DONE;
          end
        end
        DEV_DONE: begin
          if (enterRead) begin
            state <= DEV_READ;
          end
        end
        DEV_READ: begin
          if (idx == lastIdx || (selectMode && sdiRise)) begin
            state <= DEV_IDLE;
          end
        end
        default: begin
          state <= DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      convTimer <= 8'h00;
    end else if (startConv) begin
      convTimer <= 8'h00;
    end else if (state == DEV_CONV) begin
      convTimer <= convTimer + 8'h01;
    end
  end

  // mode caught from the select level just before the edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      selectMode <= 1'b1;
      chainBusy <= 1'b0;
    end else if (startConv) begin
      selectMode <= sdiPrev;
      chainBusy <= sckF;
    end
  end

  // result framing at end of conversion
  always_ff @(posedge mclk) begin
    if (rst) begin
      frame <= '0;
      lastIdx <= LAST_PLAIN;
      resultCode <= CODE_RESET;
    end else if (convEnd) begin
      resultCode <= sampleCode;
      if (busyNow) begin
        frame <= {!selectMode, sampleCode};
        lastIdx <= LAST_BUSY;
      end else begin
        frame <= {sampleCode, 1'b0};
        lastIdx <= LAST_PLAIN;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      base <= '0;
    end else if (enterRead) begin
      base <= fallCnt;
    end
  end

  // serial output driver
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.serialOutEnN <= 1'b1;
      link.serialOut <= 1'b0;
    end else begin
      unique case (state)
        DEV_READ: begin
          link.serialOutEnN <= 1'b0;
          link.serialOut <= shifted[FRAME_BITS-1];
        end
        DEV_CONV: begin
          link.serialOutEnN <= 1'b1;
          link.serialOut <= 1'b0;
        end
        default: begin
          link.serialOutEnN <= cnvF || sdiF;
          link.serialOut <= 1'b0;
        end
      endcase
    end
  end

  assign convActive = (state == DEV_CONV);
endmodule : sar_device

// ===== sar_host.sv
`timescale 1ns/1ps
module sar_host
  import sar_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic rst,
  // link
  sar_link_if.host link,
  // user request
  input wire logic startReq,
  input wire logic fourWire,
  input wire logic useBusy,
  // user answer
  output logic hostBusy,
  output logic resultValid,
  output logic [RESULT_BITS-1:0] resultCode
);
  sar_host_state_t state;
  logic modeFour;
  logic modeBusy;
  logic [7:0] timer;
  logic [4:0] divCnt;
  logic [CNT_W-1:0] pulses;
  logic [RESULT_BITS-1:0] shiftReg;
  logic lineA;
  logic lineB;
  logic lineC;
  logic lineF;

  // data line synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      lineA <= 1'b1;
      lineB <= 1'b1;
      lineC <= 1'b1;
      lineF <= 1'b1;
    end else begin
      lineA <= link.serialLine;
      lineB <= lineA;
      lineC <= lineB;
      if (lineB == lineC) begin
        lineF <= lineC;
      end
    end
  end

  logic halfDone;
  logic lastPulse;

  assign halfDone = (divCnt == SCK_HALF_CNT);
  assign lastPulse = (pulses == (modeBusy ? LAST_BUSY : LAST_PLAIN) - 5'h01);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= H_IDLE;
      modeFour <= 1'b0;
      modeBusy <= 1'b0;
      timer <= 8'h00;
      divCnt <= 5'h00;
      pulses <= '0;
      link.convertPin <= 1'b0;
      link.chainSelectIn <= 1'b1;
      link.serialClk <= 1'b0;
      shiftReg <= CODE_RESET;
      resultCode <= CODE_RESET;
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      unique case (state)
        H_IDLE: begin
          if (startReq) begin
            modeFour <= fourWire;
            modeBusy <= useBusy;
            link.convertPin <= 1'b1;
            link.chainSelectIn <= 1'b1;
            timer <= 8'h00;
            state <= H_LAUNCH;
          end
        end
        H_LAUNCH: begin
          timer <= timer + 8'h01;
          if (timer == SELECT_HOLD_CNT) begin
            if (modeBusy && modeFour) begin
              link.chainSelectIn <= 1'b0;
            end else if (modeBusy) begin
              link.convertPin <= 1'b0;
            end
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          timer <= timer + 8'h01;
          divCnt <= 5'h00;
          pulses <= '0;
          if (modeBusy ? !lineF : (timer == HOST_WAIT_CNT)) begin
            if (modeFour) begin
              link.chainSelectIn <= 1'b0;
            end else begin
              link.convertPin <= 1'b0;
            end
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          divCnt <= halfDone ? 5'h00 : divCnt + 5'h01;
          if (halfDone) begin
            link.serialClk <= !link.serialClk;
            if (!link.serialClk && !(modeBusy && pulses == '0)) begin
              shiftReg <= {shiftReg[RESULT_BITS-2:0], lineF};
            end
            if (link.serialClk) begin
              pulses <= pulses + 5'h01;
              if (lastPulse) begin
                state <= H_END;
              end
            end
          end
        end
        H_END: begin
          link.chainSelectIn <= 1'b1;
          link.convertPin <= 1'b0;
          resultCode <= shiftReg;
          resultValid <= 1'b1;
          state <= H_IDLE;
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  assign hostBusy = (state != H_IDLE);
endmodule : sar_host

// ===== sar_link_properties.sv
`timescale 1ns/1ps
module sar_link_properties (
  // system
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic convertPin,
  input wire logic chainSelectIn,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  input wire logic serialLine
);
  logic prevClk;
  logic [4:0] fallCnt;
  logic [7:0] convCnt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  always_ff @(posedge mclk) begin
    prevClk <= serialClk;
  end

  // falls counted while the line is driven
  always_ff @(posedge mclk) begin
    if (rst || serialOutEnN) begin
      fallCnt <= 5'h00;
    end else if (prevClk && !serialClk) begin
      fallCnt <= fallCnt + 5'h01;
    end
  end

  // cycles since the last convert rise, saturating
  always_ff @(posedge mclk) begin
    if (rst) begin
      convCnt <= 8'hff;
    end else if (convertPin && !$past(convertPin)) begin
      convCnt <= 8'h00;
    end else if (convCnt != 8'hff) begin
      convCnt <= convCnt + 8'h01;
    end
  end

  sequence s_start;
    $rose(convertPin) && chainSelectIn;
  endsequence

  sequence s_drive;
    $fell(serialOutEnN);
  endsequence

  a_reset_released: assert property (disable iff (1'b0) rst |=> serialOutEnN)
    else $error("line driven after reset");
  a_start_releases: assert property (s_start |-> ##[1:6] serialOutEnN)
    else $error("line not released at start");
  a_no_early_out: assert property (s_drive |-> convCnt >= 8'd30)
    else $error("line driven before conversion end");
  a_drive_selected: assert property (s_drive |-> !(convertPin && chainSelectIn))
    else $error("line driven while not selected");
  a_busy_start_low: assert property (s_drive and convCnt < 8'd45 |-> !serialOut)
    else $error("start bit not low");
  a_clock_when_driven: assert property ($changed(serialClk) |-> !serialOutEnN)
    else $error("clock moves on released line");
  a_bit_held: assert property ($rose(serialClk) |=> $stable(serialOut) [*8])
    else $error("bit changed around rising edge");
  a_falls_bounded: assert property (fallCnt <= 5'd19)
    else $error("too many falls in frame");
  a_frame_ends: assert property (fallCnt == 5'd19 |-> ##[1:6] serialOutEnN)
    else $error("line not released after last fall");
endmodule : sar_link_properties

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import sar_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic startReq = 1'b0;
  logic fourWire = 1'b0;
  logic useBusy = 1'b0;
  logic [RESULT_BITS-1:0] sampleCode = 18'h00000;
  logic hostBusy;
  logic resultValid;
  logic [RESULT_BITS-1:0] hostCode;
  logic [RESULT_BITS-1:0] devCode;
  logic convActive;
  int convLen = 0;
  int failures = 0;
  int checks = 0;
  int falls = 0;
  int expQ[$];
  logic [RESULT_BITS-1:0] edgeCodes[4] = '{18'h20000, 18'h3ffff, 18'h00000, 18'h1ffff};

  sar_link_if linkIf();
  sar_device sar_device_inst (.mclk(mclk), .rst(rst), .link(linkIf.device), .sampleCode(sampleCode),
    .convActive(convActive), .resultCode(devCode));
  sar_host sar_host_inst (.mclk(mclk), .rst(rst), .link(linkIf.host), .startReq(startReq),
    .fourWire(fourWire), .useBusy(useBusy), .hostBusy(hostBusy), .resultValid(resultValid),
    .resultCode(hostCode));
  sar_link_properties props_inst (.mclk(mclk), .rst(rst), .convertPin(linkIf.convertPin),
    .chainSelectIn(linkIf.chainSelectIn), .serialClk(linkIf.serialClk), .serialOut(linkIf.serialOut),
    .serialOutEnN(linkIf.serialOutEnN), .serialLine(linkIf.serialLine));

  initial begin
    forever #5 mclk = ~mclk;
  end

  always @(negedge linkIf.serialClk) falls++;

  // conversion length on the converter's own clock, whatever the pins do
  always @(negedge mclk) begin
    if (convActive === 1'b1) begin
      convLen++;
    end else if (convLen != 0) begin
      check(convLen, CONV_MIN_CYC);
      convLen = 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic run(input logic fw, input logic ub, input logic [RESULT_BITS-1:0] code);
    int n;
    @(negedge mclk);
    sampleCode = code;
    fourWire = fw;
    useBusy = ub;
    startReq = 1'b1;
    falls = 0;
    expQ.push_back(int'(code));
    @(negedge mclk);
    startReq = 1'b0;
    check(hostBusy, 1);
    n = 0;
    while (resultValid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check(resultValid, 1'b1);
    check(hostCode, expQ.pop_front());
    check(devCode, code);
    check(falls, 18 + ub);
    // line is released a few cycles after the last fall
    repeat (8) @(negedge mclk);
    check(linkIf.serialLine, 1);
  endtask : run

  initial begin
    void'($urandom(32'h12cf5e67));
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    check(linkIf.serialLine, 1);
    for (int i = 0; i < 16; i++) begin
      run(i[0], i[1], (i < 8) ? edgeCodes[i % 4] : RESULT_BITS'($urandom));
    end
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
endmodule : testbench
